//--- hw/spft_pkg.sv
/*
 * Constants, mode enumeration and pin bundle for the serial port frame timing block.
 * Assumes clk stands in for the crystal clock and that the mode is set while the port is idle.
 */
// Summary of operation
// RULE1: generated bit clock is the core clock divided by 64, corrected up to 163 ns
// RULE2: edge select 0 samples on rising, drives on falling; 1 inverts the clock; slave mode samples and launches on link_clk rising edges for either select
// RULE3: in serial bus mode the first timeslot window is eight bit periods wide
// RULE4: second channel strobe copies frame sync, eight bit clocks later
// RULE5: at most one phase correction per frame; receivers tolerate it
// RULE6: in slave mode the far master holds frame sync for sixteen bit clocks
// RULE7: in master mode the device holds frame sync for sixteen bit clocks
package spft_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int SPFT_CLK_PERIOD_NS = 5;
    localparam int SPFT_BIT_DIV = 64;
    localparam int SPFT_CORR_NS = 163;
    localparam int SPFT_CORR_RAW = SPFT_CORR_NS / SPFT_CLK_PERIOD_NS;
    localparam int SPFT_CORR_CYC = (SPFT_CORR_RAW < 1) ? 1 : SPFT_CORR_RAW;
    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    localparam int SPFT_WINDOW_BITS = 8;
    localparam int SPFT_STROBE_DELAY = 8;
    localparam int SPFT_IOM2_FS_BITS = 16;
    localparam int SPFT_FRAME_BITS = 32;
    localparam int SPFT_BYTE_W = 8;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SPFT_SBP,
        SPFT_IOM2_MASTER,
        SPFT_IOM2_SLAVE
    } spft_mode_t;

    typedef struct packed {
        logic bit_clock_output;
        logic bit_clock_oe;
        logic serial_frame_sync;
        logic frame_sync_oe;
        logic second_channel_strobe;
        logic serial_data_out;
    } spft_pins_t;
endpackage : spft_pkg

//--- hw/spft_port.sv
/*
 * Serial port bit and frame sequencer: serial bus mode, IOM-2 master and IOM-2 slave.
 * Assumes clk is the crystal reference; in slave mode link_clk is the far master's bit clock.
 */
`timescale 1ns/1ps
module spft_port #(
    parameter int BIT_DIV = spft_pkg::SPFT_BIT_DIV,
    parameter int FRAME_BITS = spft_pkg::SPFT_FRAME_BITS
) (
    // clocks and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    // configuration, clk domain
    input wire spft_pkg::spft_mode_t mode,
    input wire logic clock_edge_select_bit,
    input wire logic [1:0] phase_adj_req,
    // user data and pin bundle, clk domain
    input wire logic [spft_pkg::SPFT_BYTE_W-1:0] tx_data,
    input wire logic tx_load,
    output spft_pkg::spft_pins_t pins,
    output logic [spft_pkg::SPFT_BYTE_W-1:0] rx_data,
    output logic rx_valid,
    // serial pins
    input wire logic serial_data_in,
    input wire logic serial_frame_sync_in
);
    import spft_pkg::*;

    localparam int HALF = BIT_DIV / 2;
    localparam int SHRINK = (SPFT_CORR_CYC >= HALF) ? HALF - 1 : SPFT_CORR_CYC;
    localparam int BW = 8;

    initial begin
        if (BIT_DIV < 4 || BIT_DIV % 2 != 0 || HALF + SPFT_CORR_CYC > 255)
            $error("spft_port: unsupported BIT_DIV");
        if (FRAME_BITS < SPFT_STROBE_DELAY + SPFT_IOM2_FS_BITS + 1 || FRAME_BITS > 255)
            $error("spft_port: unsupported FRAME_BITS");
    end

    // ----------------------------------------
    // clk domain: bit clock generator
    // ----------------------------------------
    logic [BW-1:0] phase_reg, bit_reg;
    logic bclk_reg, adj_used_reg;
    logic [1:0] adj_pend_reg, din_sync_reg;
    logic [7:0] tx_hold_reg, tx_cur_reg, rx_shift_reg;
    logic tx_tog_reg;

    wire master = (mode != SPFT_IOM2_SLAVE);
    wire half_end = (phase_reg == '0);
    wire rise = half_end && !bclk_reg;
    wire fall = half_end && bclk_reg;
    wire frame_wrap = rise && (bit_reg == BW'(FRAME_BITS - 1));
    wire adj_go = fall && (adj_pend_reg != 2'b00) && !adj_used_reg; // RULE5
    wire [BW-1:0] low_len = adj_go ? (adj_pend_reg[0] ? BW'(HALF - 1 + SPFT_CORR_CYC)
                                                      : BW'(HALF - 1 - SHRINK))
                                   : BW'(HALF - 1); // RULE1
    wire [BW-1:0] fs_len = (mode == SPFT_SBP) ? BW'(SPFT_WINDOW_BITS) : BW'(SPFT_IOM2_FS_BITS);
    wire bclk_next = rise ? 1'b1 : (fall ? 1'b0 : bclk_reg);
    wire m_fs = bit_reg < fs_len; // RULE3 RULE7
    wire m_strobe = (bit_reg >= BW'(SPFT_STROBE_DELAY))
                    && (bit_reg < BW'(SPFT_STROBE_DELAY) + fs_len); // RULE4
    wire m_dout = (bit_reg < BW'(SPFT_BYTE_W)) ? tx_cur_reg[3'(7 - bit_reg)] : 1'b0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= BW'(HALF - 1);
            bclk_reg <= 1'b0;
            bit_reg <= BW'(FRAME_BITS - 1);
        end else begin
            bclk_reg <= bclk_next;
            if (rise)
                phase_reg <= BW'(HALF - 1);
            else if (fall)
                phase_reg <= low_len; // RULE1
            else
                phase_reg <= phase_reg - 1'b1;
            if (rise)
                bit_reg <= frame_wrap ? '0 : bit_reg + 1'b1;
        end
    end

    // one correction per frame; a new request wins over the clear of the old one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adj_pend_reg <= 2'b00;
            adj_used_reg <= 1'b0;
        end else begin
            adj_pend_reg <= phase_adj_req | (adj_go ? 2'b00 : adj_pend_reg);
            adj_used_reg <= adj_go || (adj_used_reg && !frame_wrap); // RULE5
        end
    end

    // master receive: sample on the internal rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            din_sync_reg <= 2'b00;
            rx_shift_reg <= 8'h00;
            tx_cur_reg <= 8'h00;
        end else begin
            din_sync_reg <= {din_sync_reg[0], serial_data_in};
            if (rise && bit_reg < BW'(SPFT_BYTE_W))
                rx_shift_reg <= {rx_shift_reg[6:0], din_sync_reg[1]}; // RULE2
            if (frame_wrap)
                tx_cur_reg <= tx_hold_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold_reg <= 8'h00;
            tx_tog_reg <= 1'b0;
        end else if (tx_load) begin
            tx_hold_reg <= tx_data;
            tx_tog_reg <= !tx_tog_reg;
        end
    end

    // ----------------------------------------
    // link domain: slave mode, clocked by the far master
    // ----------------------------------------
    logic [2:0] l_txtog_sync;
    logic l_fs_prev, l_rx_tog, l_dout, l_strobe;
    logic [BW-1:0] l_bit;
    logic [7:0] l_shift, l_rx_word, l_tx;

    wire l_fs_rise = serial_frame_sync_in && !l_fs_prev; // RULE6
    wire [BW-1:0] l_idx = l_fs_rise ? '0 : ((l_bit == '1) ? l_bit : l_bit + 1'b1);
    // wrap at the frame end so the first bit of the next frame is launched in time
    wire [BW-1:0] l_nidx = (l_idx == BW'(FRAME_BITS - 1)) ? '0 : l_idx + 1'b1;
    wire l_tx_new = l_txtog_sync[1] != l_txtog_sync[2];

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            l_txtog_sync <= 3'b000;
            l_fs_prev <= 1'b0;
            l_bit <= '1;
            l_shift <= 8'h00;
            l_rx_word <= 8'h00;
            l_rx_tog <= 1'b0;
            l_tx <= 8'h00;
            l_dout <= 1'b0;
            l_strobe <= 1'b0;
        end else begin
            l_txtog_sync <= {l_txtog_sync[1:0], tx_tog_reg};
            l_fs_prev <= serial_frame_sync_in;
            l_bit <= l_idx;
            if (l_tx_new)
                l_tx <= tx_hold_reg;
            // no mode gate: a gate synced in here would need link edges the stopped clock lacks
            if (l_idx < BW'(SPFT_BYTE_W))
                l_shift <= {l_shift[6:0], serial_data_in};
            if (l_idx == BW'(SPFT_BYTE_W - 1)) begin
                l_rx_word <= {l_shift[6:0], serial_data_in};
                l_rx_tog <= !l_rx_tog;
            end
            l_dout <= (l_nidx < BW'(SPFT_BYTE_W)) ? l_tx[3'(7 - l_nidx)] : 1'b0;
            l_strobe <= (l_nidx >= BW'(SPFT_STROBE_DELAY))
                        && (l_nidx < BW'(SPFT_STROBE_DELAY + SPFT_IOM2_FS_BITS)); // RULE4
        end
    end

    // ----------------------------------------
    // clk domain: crossings back and pin outputs
    // ----------------------------------------
    logic [2:0] rxtog_sync;
    logic [1:0] sdout_sync, sstrb_sync;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxtog_sync <= 3'b000;
            sdout_sync <= 2'b00;
            sstrb_sync <= 2'b00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rxtog_sync <= {rxtog_sync[1:0], l_rx_tog};
            sdout_sync <= {sdout_sync[0], l_dout};
            sstrb_sync <= {sstrb_sync[0], l_strobe};
            rx_valid <= master ? (rise && bit_reg == BW'(SPFT_BYTE_W - 1))
                               : (rxtog_sync[1] != rxtog_sync[2]);
            if (master && rise && bit_reg == BW'(SPFT_BYTE_W - 1))
                rx_data <= {rx_shift_reg[6:0], din_sync_reg[1]};
            else if (!master && rxtog_sync[1] != rxtog_sync[2])
                rx_data <= l_rx_word;
        end
    end

    // in master modes outputs change on the internal falling edge; the pin clock is inverted when selected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins <= '0;
        end else begin
            pins.bit_clock_output <= bclk_next ^ clock_edge_select_bit; // RULE2
            pins.bit_clock_oe <= master;
            pins.frame_sync_oe <= master;
            if (!master) begin
                pins.serial_frame_sync <= 1'b0;
                pins.second_channel_strobe <= sstrb_sync[1];
                pins.serial_data_out <= sdout_sync[1];
            end else if (fall) begin
                pins.serial_frame_sync <= m_fs; // RULE3 RULE7
                pins.second_channel_strobe <= m_strobe; // RULE4
                pins.serial_data_out <= m_dout; // RULE2
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [BW-1:0] per_cnt, fsr_cnt;
    logic adj_in_per, per_valid;
    logic [1:0] adj_frame_cnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_cnt <= '0;
            fsr_cnt <= '0;
            adj_in_per <= 1'b0;
            per_valid <= 1'b0;
            adj_frame_cnt <= 2'b00;
        end else begin
            per_cnt <= rise ? '0 : per_cnt + 1'b1;
            adj_in_per <= rise ? 1'b0 : (adj_in_per || adj_go);
            per_valid <= per_valid || rise;
            adj_frame_cnt <= frame_wrap ? 2'b00 : adj_frame_cnt + {1'b0, adj_go};
            if (master && fall && m_fs && !pins.serial_frame_sync)
                fsr_cnt <= '0;
            else if (rise && fsr_cnt != '1)
                fsr_cnt <= fsr_cnt + 1'b1;
        end
    end

    sequence s_internal_rise;
        master && rise;
    endsequence

    a_bit_period: assert property (@(posedge clk) disable iff (!nrst)
        (rise && per_valid && !adj_in_per) |-> per_cnt == BW'(BIT_DIV - 1)) // RULE1
        else $error("bit period differs from divider");
    a_corr_bound: assert property (@(posedge clk) disable iff (!nrst)
        (rise && per_valid) |-> per_cnt <= BW'(BIT_DIV - 1 + SPFT_CORR_CYC)) // RULE1
        else $error("bit period beyond correction limit");
    a_edge_sense: assert property (@(posedge clk) disable iff (!nrst)
        s_internal_rise |=> pins.bit_clock_output == !clock_edge_select_bit) // RULE2
        else $error("bit clock polarity wrong");
    a_window_width: assert property (@(posedge clk) disable iff (!nrst)
        (mode == SPFT_SBP) && $fell(pins.serial_frame_sync)
        |-> fsr_cnt == BW'(SPFT_WINDOW_BITS)) // RULE3
        else $error("first window not eight bit periods");
    a_strobe_delay: assert property (@(posedge clk) disable iff (!nrst)
        master && $rose(pins.second_channel_strobe)
        |-> fsr_cnt == BW'(SPFT_STROBE_DELAY)) // RULE4
        else $error("strobe not eight bit clocks after frame sync");
    a_corr_once: assert property (@(posedge clk) disable iff (!nrst)
        adj_frame_cnt <= 2'd1) // RULE5
        else $error("more than one correction in a frame");
    a_iom2_fs: assert property (@(posedge clk) disable iff (!nrst)
        (mode == SPFT_IOM2_MASTER) && $fell(pins.serial_frame_sync)
        |-> fsr_cnt == BW'(SPFT_IOM2_FS_BITS)) // RULE7
        else $error("master frame sync not sixteen bit clocks");
endmodule : spft_port

//--- tb/spft_far_end.sv
/*
 * Far-end link master model: bit clock, frame sync and one byte per frame.
 * Assumes the bench holds run low outside slave mode.
 */
`timescale 1ns/1ps
module spft_far_end (
    // control
    input wire logic run,
    input wire logic [7:0] byte_in,
    // link pins
    output logic link_clk,
    output logic fs,
    output logic din
);
    import spft_pkg::*;
    // ----
    // frames
    // ----
    logic [7:0] sh;
    initial begin
        link_clk = 1'b0;
        fs = 1'b0;
        din = 1'b0;
        sh = 8'h00;
        forever begin
            if (!run) begin
                #100;
                din = ~din; // released line moves, so a stale bit never passes
            end else begin
                sh = byte_in;
                for (int i = 0; i < SPFT_FRAME_BITS; i++) begin
                    fs = (i < SPFT_IOM2_FS_BITS);
                    din = (i < 8) ? sh[7 - i] : ~din;
                    #62.5 link_clk = 1'b1;
                    #62.5 link_clk = 1'b0;
                end
                #200; // clock stands still between frames
            end
        end
    end
endmodule : spft_far_end

//--- tb/spft_port_tb.sv
/*
 * Self-checking bench for spft_port in all three modes.
 * Assumes loopback of the data pin in master modes and the far-end model in slave mode.
 */
`timescale 1ns/1ps
module spft_port_tb;
    import spft_pkg::*;
    // ----
    // signals
    // ----
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic sel = 1'b0;
    logic adj = 1'b0;
    logic tx_load = 1'b0;
    logic [1:0] phase_adj_req = 2'h0;
    logic [7:0] tx_data = 8'h00;
    logic [16:0] lf = 17'h16d9b;
    spft_mode_t mode = SPFT_SBP;
    spft_pins_t pins;
    logic [7:0] rx_data;
    logic rx_valid, link_clk, fe_fs, fe_din, ck, ckp, fsp, stp;
    logic [7:0] expq[$];
    int miscompares = 0, checked = 0, cyc = 0, tf = 0, per = 0, longs = 0, lpf = 0;
    int li = 0, lfr = 0;
    logic lfsp = 1'b0;
    wire mst = (mode != SPFT_IOM2_SLAVE);
    always #2.5 clk = ~clk;
    spft_far_end fe (.run(run), .byte_in(tx_data), .link_clk(link_clk), .fs(fe_fs),
        .din(fe_din));
    spft_port dut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .mode(mode),
        .clock_edge_select_bit(sel), .phase_adj_req(phase_adj_req), .tx_data(tx_data),
        .tx_load(tx_load), .pins(pins), .rx_data(rx_data), .rx_valid(rx_valid),
        .serial_data_in(mst ? pins.serial_data_out : fe_din), .serial_frame_sync_in(fe_fs));
    // ----
    // helpers
    // ----
    function automatic logic [16:0] lfsr(logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction : lfsr
    task check(logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task conclude;
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task load; // byte sent now comes back in the next frame
        lf = lfsr(lf);
        @(posedge clk);
        #1;
        tx_data = lf[7:0];
        tx_load = 1'b1;
        expq.push_back(lf[7:0]);
        @(posedge clk);
        #1 tx_load = 1'b0;
        // two requests in one frame: only one may take effect there
        repeat (2) if (adj) begin
            repeat (100) @(posedge clk);
            #1 phase_adj_req = 2'h1;
            @(posedge clk);
            #1 phase_adj_req = 2'h0;
        end
    endtask : load
    task wait_rx;
        int i;
        for (i = 0; i < 5000 && rx_valid !== 1'b1; i++) @(negedge clk);
        if (i == 5000) begin
            miscompares++;
            conclude();
        end
    endtask : wait_rx
    task run_mode(spft_mode_t m, logic s, logic a, int n);
        @(posedge clk);
        #1 nrst = 1'b0;
        mode = m;
        sel = s;
        adj = a;
        run = 1'b0;
        longs = 0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        load();
        run = !mst;
        for (int k = 1; k <= n; k++) begin
            wait_rx();
            if (k < n) load();
        end
        @(negedge clk); // the monitor takes the last note at the previous edge
        check(expq.size(), 0);
        if (a) check(longs > 0, 1);
        check(pins.frame_sync_oe, mst);
        check(pins.bit_clock_oe, mst);
    endtask : run_mode
    // ----
    // monitor
    // ----
    always @(negedge clk) begin
        cyc++;
        ck = pins.bit_clock_output ^ sel;
        if (nrst !== 1'b1) begin
            per = 0;
            lpf = 0;
        end else if (mst) begin
            if (ck && !ckp) begin
                if (per == SPFT_BIT_DIV + SPFT_CORR_CYC) begin
                    longs++;
                    lpf++;
                end else if (per != 0) check(per, SPFT_BIT_DIV);
                per = 1;
            end else if (per != 0) per++;
            if (pins.serial_frame_sync !== fsp) check(ck, 0);
            if (pins.serial_frame_sync && !fsp) begin
                tf = cyc;
                check(lpf > 1, 0);
                lpf = 0;
            end
            if (!pins.serial_frame_sync && fsp && !adj)
                check(cyc - tf, SPFT_BIT_DIV * ((mode == SPFT_SBP) ? SPFT_WINDOW_BITS
                    : SPFT_IOM2_FS_BITS));
            if (pins.second_channel_strobe && !stp && !adj)
                check(cyc - tf, SPFT_BIT_DIV * SPFT_STROBE_DELAY);
        end
        if (rx_valid === 1'b1) check(rx_data, expq.pop_front());
        ckp = ck;
        fsp = pins.serial_frame_sync;
        stp = pins.second_channel_strobe;
    end
    // slave side: the far master samples strobe and data on its rising edge
    always @(posedge link_clk) begin
        if (fe_fs && !lfsp) begin
            li = 0;
            lfr++;
        end else li++;
        lfsp = fe_fs;
        if (!mst && nrst === 1'b1) begin
            check(pins.serial_frame_sync, 0);
            check(pins.second_channel_strobe, li >= SPFT_STROBE_DELAY
                && li < SPFT_STROBE_DELAY + SPFT_IOM2_FS_BITS);
            // from the second frame on both ends carry the same loaded byte
            if (lfr > 1 && li < 8) check(pins.serial_data_out, fe.sh[7 - li]);
        end
    end
    // ----
    // sequence
    // ----
    initial begin
        run_mode(SPFT_SBP, 1'b0, 1'b0, 4);
        run_mode(SPFT_SBP, 1'b1, 1'b1, 4);
        run_mode(SPFT_IOM2_MASTER, 1'b1, 1'b0, 3);
        run_mode(SPFT_IOM2_SLAVE, 1'b0, 1'b0, 3);
        conclude();
    end
endmodule : spft_port_tb
